// ### rtl/crb_pkg.sv
// Shared constants and types for the control-register bus handshake
package crb_pkg;

  // ********************************************************************
  // Bus widths
  // ********************************************************************
  localparam int CRB_ADDR_W = 10;
  localparam int CRB_DATA_W = 32;

  // ********************************************************************
  // Handshake timing
  // ********************************************************************
  localparam int CRB_CLK_MHZ = 50;
  // Acknowledge wait limit, in processor cycles
  localparam int CRB_TIMEOUT_CYC = 64;
  localparam logic [6:0] CRB_TIMEOUT_CNT = 7'(CRB_TIMEOUT_CYC);
  // Request drops this many cycles after the synchronised acknowledge rises
  localparam logic [1:0] CRB_REQ_HOLD = 2'h2;
  // Idle cycles after the acknowledge falls before a new address
  localparam logic [1:0] CRB_GAP_CYC = 2'h1;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [CRB_DATA_W-1:0] CRB_DATA_RST = 32'h0000_0000;
  localparam logic [CRB_ADDR_W-1:0] CRB_ADDR_RST = 10'h000;

  // ********************************************************************
  // Processor-side states
  // ********************************************************************
  typedef enum logic [3:0] {
    CRB_IDLE = 4'h1,
    CRB_ADDR = 4'h2,
    CRB_REQ = 4'h4,
    CRB_GAP = 4'h8
  } crb_state_type;

endpackage

// ### rtl/crb_if.sv
// Interface joining the processor end and a register slave end
`timescale 1ns/10ps
`default_nettype none
interface crb_if;
  import crb_pkg::*;
  logic ctrl_reg_read_req;
  logic ctrl_reg_write_req;
  logic [CRB_ADDR_W-1:0] ctrl_reg_addr_bus;
  logic [CRB_DATA_W-1:0] ctrl_reg_wdata_out;
  logic ctrl_reg_access_ack;
  logic [CRB_DATA_W-1:0] ctrl_reg_rdata_in;

  modport proc
  (
    output ctrl_reg_read_req,
    output ctrl_reg_write_req,
    output ctrl_reg_addr_bus,
    output ctrl_reg_wdata_out,
    input ctrl_reg_access_ack,
    input ctrl_reg_rdata_in
  );

  modport slave
  (
    input ctrl_reg_read_req,
    input ctrl_reg_write_req,
    input ctrl_reg_addr_bus,
    input ctrl_reg_wdata_out,
    output ctrl_reg_access_ack,
    output ctrl_reg_rdata_in
  );
endinterface
`default_nettype wire

// ### rtl/crb_proc.sv
// Processor end of the control-register bus handshake
`timescale 1ns/10ps
`default_nettype none
module crb_proc
  import crb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  crb_if.proc bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [CRB_ADDR_W-1:0] cmd_addr,
  input wire logic [CRB_DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic timed_out,
  output logic [CRB_DATA_W-1:0] rdata
);

  // ********************************************************************
  // Acknowledge synchroniser
  // ********************************************************************
  // The slave may run on another clock, so ack is resynchronised here
  logic ack_s1_r, ack_s1_nxt;
  logic ack_s2_r, ack_s2_nxt;

  always_comb
  begin
    // Latched or combinational ack alike is only used once settled
    ack_s1_nxt = bus.ctrl_reg_access_ack;
    ack_s2_nxt = ack_s1_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= ack_s1_nxt;
      ack_s2_r <= ack_s2_nxt;
    end
  end

  // ********************************************************************
  // Request sequencer
  // ********************************************************************
  crb_state_type state_r, state_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic is_wr_r, is_wr_nxt;
  logic [CRB_ADDR_W-1:0] addr_r, addr_nxt;
  logic [CRB_DATA_W-1:0] wdat_r, wdat_nxt;
  logic [CRB_DATA_W-1:0] rdata_r, rdata_nxt;
  logic [6:0] wait_r, wait_nxt;
  logic [1:0] hold_r, hold_nxt;
  logic acked_r, acked_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic tout_r, tout_nxt;

  always_comb
  begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    is_wr_nxt = is_wr_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdata_nxt = rdata_r;
    wait_nxt = wait_r;
    hold_nxt = hold_r;
    acked_nxt = acked_r;
    ready_nxt = 1'b0;
    done_nxt = 1'b0;
    tout_nxt = 1'b0;
    unique case (state_r)
      CRB_IDLE:
      begin
        ready_nxt = 1'b1;
        if (cmd_valid && ready_r)
        begin
          ready_nxt = 1'b0;
          // Address leads the request by one cycle
          addr_nxt = cmd_addr;
          is_wr_nxt = cmd_write;
          wdat_nxt = cmd_write ? cmd_wdata : CRB_DATA_RST;
          state_nxt = CRB_ADDR;
        end
      end
      CRB_ADDR:
      begin
        rd_nxt = !is_wr_r;
        wr_nxt = is_wr_r;
        wait_nxt = 7'h00;
        hold_nxt = 2'h0;
        acked_nxt = 1'b0;
        state_nxt = CRB_REQ;
      end
      CRB_REQ:
      begin
        if (acked_r || ack_s2_r)
        begin
          if (!acked_r && !is_wr_r)
          begin
            rdata_nxt = bus.ctrl_reg_rdata_in;
          end
          acked_nxt = 1'b1;
          hold_nxt = hold_r + 2'h1;
          if (hold_r + 2'h1 == CRB_REQ_HOLD)
          begin
            rd_nxt = 1'b0;
            wr_nxt = 1'b0;
            done_nxt = 1'b1;
            hold_nxt = 2'h0;
            state_nxt = CRB_GAP;
          end
        end
        else if (wait_r + 7'h01 == CRB_TIMEOUT_CNT)
        begin
          // No error: the access is simply dropped
          rd_nxt = 1'b0;
          wr_nxt = 1'b0;
          tout_nxt = 1'b1;
          hold_nxt = 2'h0;
          state_nxt = CRB_GAP;
        end
        else
        begin
          wait_nxt = wait_r + 7'h01;
        end
      end
      CRB_GAP:
      begin
        // Synchronised ack low already covers the unaligned-edge case
        // Only the second stage is read: the first may still be metastable
        if (!ack_s2_r)
        begin
          hold_nxt = hold_r + 2'h1;
          if (hold_r + 2'h1 >= CRB_GAP_CYC)
          begin
            wdat_nxt = CRB_DATA_RST;
            state_nxt = CRB_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = CRB_IDLE;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r <= CRB_IDLE;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      is_wr_r <= 1'b0;
      addr_r <= CRB_ADDR_RST;
      wdat_r <= CRB_DATA_RST;
      rdata_r <= CRB_DATA_RST;
      wait_r <= 7'h00;
      hold_r <= 2'h0;
      acked_r <= 1'b0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      tout_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      is_wr_r <= is_wr_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      hold_r <= hold_nxt;
      acked_r <= acked_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      tout_r <= tout_nxt;
    end
  end

  assign bus.ctrl_reg_read_req = rd_r;
  assign bus.ctrl_reg_write_req = wr_r;
  assign bus.ctrl_reg_addr_bus = addr_r;
  assign bus.ctrl_reg_wdata_out = wdat_r;
  assign cmd_ready = ready_r;
  assign done = done_r;
  assign timed_out = tout_r;
  assign rdata = rdata_r;

endmodule
`default_nettype wire

// ### rtl/crb_slave.sv
// Register slave end of the control-register bus handshake
`timescale 1ns/10ps
`default_nettype none
module crb_slave
  import crb_pkg::*;
#(
  parameter logic [CRB_ADDR_W-1:0] BASE_ADDR = 10'h000,
  parameter bit MODE1 = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic srst,
  crb_if.slave bus,
  input wire logic [CRB_DATA_W-1:0] chain_in,
  input wire logic [CRB_DATA_W-1:0] status_in,
  output logic [CRB_DATA_W-1:0] ctrl_out
);

  // ********************************************************************
  // Latched acknowledge and chained data
  // ********************************************************************
  // Two registers: word 0 is control (read/write), word 1 status input
  function automatic logic hit(input logic [CRB_ADDR_W-1:0] a);
    return a[CRB_ADDR_W-1:1] == BASE_ADDR[CRB_ADDR_W-1:1];
  endfunction

  logic req;
  logic sel;
  logic ack_r, ack_nxt;
  logic pulsed_r, pulsed_nxt;
  logic [CRB_DATA_W-1:0] dout_r, dout_nxt;
  logic [CRB_DATA_W-1:0] ctrl_r, ctrl_nxt;

  assign req = bus.ctrl_reg_read_req | bus.ctrl_reg_write_req;
  assign sel = req && hit(bus.ctrl_reg_addr_bus);

  always_comb
  begin
    ack_nxt = 1'b0;
    pulsed_nxt = pulsed_r;
    ctrl_nxt = ctrl_r;
    dout_nxt = chain_in;
    if (!req)
    begin
      pulsed_nxt = 1'b0;
    end
    if (sel)
    begin
      if (bus.ctrl_reg_read_req)
      begin
        dout_nxt = bus.ctrl_reg_addr_bus[0] ? status_in : ctrl_r;
      end
      if (MODE1)
      begin
        ack_nxt = !ack_r && !pulsed_r;
        pulsed_nxt = 1'b1;
      end
      else
      begin
        ack_nxt = 1'b1;
      end
      if (bus.ctrl_reg_write_req && !bus.ctrl_reg_addr_bus[0] && !ack_r
          && !pulsed_r)
      begin
        ctrl_nxt = bus.ctrl_reg_wdata_out;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ack_r <= 1'b0;
      pulsed_r <= 1'b0;
      dout_r <= CRB_DATA_RST;
      ctrl_r <= CRB_DATA_RST;
    end
    else
    begin
      ack_r <= ack_nxt;
      pulsed_r <= pulsed_nxt;
      dout_r <= dout_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign bus.ctrl_reg_access_ack = ack_r;
  assign bus.ctrl_reg_rdata_in = dout_r;
  assign ctrl_out = ctrl_r;

endmodule
`default_nettype wire

// ### testbench/crb_chk.sv
// Handshake checker for the control-register bus
`timescale 1ns/10ps
`default_nettype none
module crb_chk
  import crb_pkg::*;
#(
  parameter logic [CRB_ADDR_W-1:0] BASE_ADDR = 10'h000
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ctrl_reg_read_req,
  input wire logic ctrl_reg_write_req,
  input wire logic [CRB_ADDR_W-1:0] ctrl_reg_addr_bus,
  input wire logic [CRB_DATA_W-1:0] ctrl_reg_wdata_out,
  input wire logic ctrl_reg_access_ack,
  input wire logic [CRB_DATA_W-1:0] ctrl_reg_rdata_in
);
  logic req;
  logic own;
  assign req = ctrl_reg_read_req | ctrl_reg_write_req;
  assign own = ctrl_reg_addr_bus[CRB_ADDR_W-1:1]
    == BASE_ADDR[CRB_ADDR_W-1:1];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_own;
    own;
  endsequence
  a_one_direction: assert property (
    !(ctrl_reg_read_req && ctrl_reg_write_req))
    else $error("read and write requested together");
  a_ack_held: assert property (
    ctrl_reg_access_ack && req |=> ctrl_reg_access_ack)
    else $error("acknowledge dropped under request");
  a_ack_follows: assert property (
    s_start ##0 s_own |=> ctrl_reg_access_ack)
    else $error("acknowledge late");
  a_ack_release: assert property (
    $fell(req) |=> !ctrl_reg_access_ack)
    else $error("acknowledge not released");
  a_req_drop: assert property (
    $rose(ctrl_reg_access_ack) |-> ##[1:6] !req)
    else $error("request held too long after acknowledge");
  a_req_abandon: assert property (
    s_start |-> ##[1:70] !req)
    else $error("request never abandoned");
  a_read_zero: assert property (
    ctrl_reg_read_req |-> ctrl_reg_wdata_out == '0)
    else $error("write data not zero on read");
  a_addr_stable: assert property (
    req && $past(req) |-> $stable(ctrl_reg_addr_bus))
    else $error("address moved during request");
  a_start_gap: assert property (
    s_start |-> !$past(ctrl_reg_access_ack))
    else $error("new request without idle acknowledge cycle");
  a_ack_owned: assert property (
    $rose(ctrl_reg_access_ack) |-> $past(req && own))
    else $error("acknowledge for a foreign address");
  a_rdata_steady: assert property (
    ctrl_reg_read_req && ctrl_reg_access_ack && $past(ctrl_reg_access_ack)
      |-> $stable(ctrl_reg_rdata_in))
    else $error("read data moved under acknowledge");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench joining the processor end to one slave end
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("mismatch %0t got %h exp %h", $time, a, b); \
    end \
  end
module testbench;
  import crb_pkg::*;
  localparam logic [CRB_ADDR_W-1:0] BASE = 10'h1a4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [CRB_ADDR_W-1:0] cmd_addr = '0;
  logic [CRB_DATA_W-1:0] cmd_wdata = '0;
  logic [CRB_DATA_W-1:0] status_in = 32'h3c5a_0f96;
  logic cmd_ready;
  logic done;
  logic timed_out;
  logic [CRB_DATA_W-1:0] rdata;
  logic [CRB_DATA_W-1:0] ctrl_out;
  logic got_done;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int took;
  crb_if bus();
  crb_proc u_crb_proc (.ref_clk(ref_clk), .srst(srst), .bus(bus.proc),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
    .timed_out(timed_out), .rdata(rdata));
  crb_slave #(.BASE_ADDR(BASE), .MODE1(1'b0)) u_crb_slave (.ref_clk(ref_clk),
    .srst(srst), .bus(bus.slave), .chain_in(32'h0000_0000),
    .status_in(status_in), .ctrl_out(ctrl_out));
  crb_chk #(.BASE_ADDR(BASE)) u_crb_chk (.ref_clk(ref_clk), .srst(srst),
    .ctrl_reg_read_req(bus.ctrl_reg_read_req),
    .ctrl_reg_write_req(bus.ctrl_reg_write_req),
    .ctrl_reg_addr_bus(bus.ctrl_reg_addr_bus),
    .ctrl_reg_wdata_out(bus.ctrl_reg_wdata_out),
    .ctrl_reg_access_ack(bus.ctrl_reg_access_ack),
    .ctrl_reg_rdata_in(bus.ctrl_reg_rdata_in));
  always #10 ref_clk = ~ref_clk;
  // ******************************************************************
  // Closing report and hang limit
  // ******************************************************************
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Three short scenarios need well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // ******************************************************************
  // One access, with the wire checked while the request stands
  // ******************************************************************
  task automatic access(input logic wr, input logic [CRB_ADDR_W-1:0] a,
    input logic [CRB_DATA_W-1:0] d);
    int t0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    do
      @(negedge ref_clk);
    while (cmd_ready !== 1'b1);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    // Cycle count is read off the edge so it cannot race the counter
    @(negedge ref_clk);
    t0 = cyc;
    while ((bus.ctrl_reg_read_req | bus.ctrl_reg_write_req) !== 1'b1
      && cyc - t0 < 200)
      @(negedge ref_clk);
    `CHK(bus.ctrl_reg_addr_bus, a)
    `CHK(bus.ctrl_reg_wdata_out, wr ? d : 32'h0000_0000)
    while (done !== 1'b1 && timed_out !== 1'b1 && cyc - t0 < 200)
      @(negedge ref_clk);
    got_done = done;
    took = cyc - t0;
    `CHK(got_done | timed_out, 1'b1)
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_write_read();
    access(1'b1, BASE, 32'h9e37_79b9);
    `CHK(got_done, 1'b1)
    `CHK(ctrl_out, 32'h9e37_79b9)
    access(1'b0, BASE, 32'h0000_0000);
    `CHK(rdata, 32'h9e37_79b9)
    access(1'b0, BASE + 10'h001, 32'h0000_0000);
    `CHK(rdata, status_in)
  endtask
  task automatic t_back_to_back();
    int t1;
    access(1'b1, BASE, 32'h0000_00ff);
    t1 = cyc;
    access(1'b0, BASE, 32'h0000_0000);
    `CHK(cyc - t1 >= 7, 1'b1)
    `CHK(rdata, 32'h0000_00ff)
  endtask
  // An address nobody owns is never acknowledged, so the access lapses
  task automatic t_unmapped();
    access(1'b0, BASE + 10'h002, 32'h0000_0000);
    `CHK(got_done, 1'b0)
    `CHK(took >= CRB_TIMEOUT_CYC, 1'b1)
    // Address leads the request by one cycle, then the full wait runs out
    `CHK(took, CRB_TIMEOUT_CYC + 1)
    `CHK(rdata, 32'h0000_00ff)
    access(1'b1, BASE, 32'h5a5a_0001);
    `CHK(ctrl_out, 32'h5a5a_0001)
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_write_read();
    t_back_to_back();
    t_unmapped();
    stop_test();
  end
endmodule
`default_nettype wire
